/* File: pkg/external_memory_interface_defines.svh */
// Offsets, field positions, reset values and timing counts of the
// external memory configuration block.
// Assumes byte addresses on a 32-bit APB, one register per aligned word.
`ifndef EXTERNAL_MEMORY_INTERFACE_DEFINES_SVH
`define EXTERNAL_MEMORY_INTERFACE_DEFINES_SVH

// Register byte offsets
`define OFS_BUS_CONFIG   8'h00
`define OFS_MEM_CTRL     8'h04
`define OFS_PORT_DIR     8'h08
`define OFS_PORT_OUT     8'h0c
`define OFS_STATUS       8'h10

// Fields of external_bus_config
`define CFG_KEEPER_BIT   7
`define CFG_RES_MSB      6
`define CFG_RES_LSB      3
`define CFG_MASK_MSB     2
`define CFG_MASK_LSB     0

// Fields of the memory control register
`define CTRL_ENABLE_BIT  0
`define CTRL_LEGACY_BIT  1

// Reset values
`define RST_BUS_CONFIG   8'h00
`define RST_MEM_CTRL     2'h0
`define RST_PORT_DIR     8'h00
`define RST_PORT_OUT     8'h00

// Top of internal data space, normal and legacy layout
`define INT_TOP_NORMAL   16'h10ff
`define INT_TOP_LEGACY   16'h0fff

// Number of high-address pins
`define HI_PINS          8

// Timing: clock period, strobe width, input settle time
`define CLK_NS           10
`define STROBE_NS        20
`define STROBE_CYC       ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_CYC         4

`endif

/* File: pkg/external_memory_interface_pkg.sv */
// Types shared by the external memory configuration block.
// Assumes external_memory_interface_defines.svh for all numeric constants.
package external_memory_interface_pkg;

   // Cycle sequencer states, gray coded along the read path from idle to done
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_LATCH  = 3'b011,
      ST_STROBE = 3'b010,
      ST_SETTLE = 3'b110,
      ST_DONE   = 3'b111
   } external_memory_interface_state_e;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   // APB answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   // CPU data-space request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cpu_req_s;

   // CPU data-space answer
   typedef struct packed {
      logic        ready;
      logic [7:0]  rdata;
      logic        internal;
      logic        fault;
   } cpu_rsp_s;

   // External bus pins, driven side
   typedef struct packed {
      logic [7:0] ad_out;
      logic       ad_oe;
      logic       ad_keep_oe;
      logic [7:0] hi_out;
      logic [7:0] hi_oe;
      logic       ale;
      logic       wr_n;
      logic       rd_n;
      logic       ctl_oe;
   } xbus_s;

endpackage

/* File: core/external_memory_interface_pin_sync.sv */
// Three-stage input synchroniser for pin inputs.
// Assumes input from outside the core_clk domain; output follows once
// stages two and three agree.
module external_memory_interface_pin_sync #(
   parameter int W = 8
) (
   input  wire logic         core_clk,  // System clock
   input  wire logic         rst_n,     // Async reset, active low
   input  wire logic [W-1:0] pin_in,    // Raw pin level
   output logic      [W-1:0] pin_sync   // Filtered level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_state_s;

   sync_state_s sync_reg;
   sync_state_s sync_next;

   // Shift chain; per-bit update only on agreement of stages two and three
   always_comb begin
      sync_next    = sync_reg;
      sync_next.s1 = pin_in;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (sync_reg.s2[i] == sync_reg.s3[i]) begin
            sync_next.q[i] = sync_reg.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign pin_sync = sync_reg.q;

endmodule

/* File: core/external_memory_interface_hi_pin.sv */
// One high-address pin: memory interface or ordinary port function.
// Assumes mask, enable and port settings come from registers on core_clk.
`include "external_memory_interface_defines.svh"

module external_memory_interface_hi_pin #(
   parameter int IDX = 0
) (
   input  wire logic       ext_en,     // External memory enable
   input  wire logic [2:0] mask,       // High address mask field
   input  wire logic       addr_bit,   // Address bit for this pin
   input  wire logic       port_dir,   // Port direction, 1 drives
   input  wire logic       port_out,   // Port output level
   output logic            pin_out,    // Pin level when driven
   output logic            pin_oe      // Pin output enable
);

   logic released;

   // Mask k frees the top k pins; all ones frees the whole port
   always_comb begin
      released = (mask == 3'h7) || ((int'(mask) + IDX) >= `HI_PINS);
   end

   // Interface owns unreleased pins, else ordinary port settings
   always_comb begin
      if (ext_en && !released) begin
         pin_out = addr_bit;
         pin_oe  = 1'b1;
      end else begin
         pin_out = port_out;
         pin_oe  = port_dir;
      end
   end

endmodule

/* File: core/external_memory_interface_ctrl.sv */
// External memory interface configuration and cycle sequencer.
// Assumes an APB master for registers, a CPU data port that holds its
// request until ready, and external SRAM on a multiplexed bus with latch.
//
// Overview of operation
// R1: Keeper enabled holds last level on muxed lines while nothing drives them.
// R2: Keeper works whenever enabled, whether or not the interface is enabled.
// R3: Config bits 6..3 read as zero; software writes them as zero.
// R4: Enabled interface with zero mask drives all eight high-address pins.
// R5: Mask k frees top k pins from pin 7 down; seven frees all.
// R6: Freed pins follow the port's own direction and output settings.
// R7: Addresses up to 0x10ff are internal and start no external cycle.
// R8: Full sixteen-bit address is driven, so small memories alias upward.
// R9: Software avoids addresses above 0x90ff on a memory without top bit.
// R10: Legacy mode internal space is 4096 bytes; external starts at 0x1000.
// R11: Freed pins at port zero let software reach external 0x0000 to 0x1fff.
// R12: Enable bit hands muxed, high, latch and strobe pins to the interface.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`include "external_memory_interface_defines.svh"

module external_memory_interface_ctrl (
   input  wire logic              core_clk,  // System clock, 100 MHz
   input  wire logic              rst_n,     // Async reset, active low
   input  wire external_memory_interface_pkg::apb_req_s apb_req,  // APB request
   output external_memory_interface_pkg::apb_rsp_s      apb_rsp,  // APB answer
   input  wire external_memory_interface_pkg::cpu_req_s cpu_req,  // CPU data-space request
   output external_memory_interface_pkg::cpu_rsp_s      cpu_rsp,  // CPU data-space answer
   input  wire logic [7:0]         ad_in,    // Muxed lines, pin level
   output external_memory_interface_pkg::xbus_s         xbus      // External bus pins
);
   import external_memory_interface_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////////

   typedef struct packed {
      logic [7:0]  cfg;
      logic [1:0]  ctrl;
      logic [7:0]  pdir;
      logic [7:0]  pout;
      external_memory_interface_state_e st;
      logic [2:0]  cnt;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        write;
      logic [7:0]  rdata;
      logic [7:0]  keep;
      logic [7:0]  ad_val;
      logic        ad_oe;
      logic        ale;
      logic        wr_n;
      logic        rd_n;
      logic [31:0] prdata;
      logic        pslverr;
   } ctrl_state_s;

   ctrl_state_s r_reg;
   ctrl_state_s r_next;

   logic [7:0]  ad_sync;
   logic [7:0]  hi_out;
   logic [7:0]  hi_oe;
   logic        ext_en;
   logic        legacy;
   logic [2:0]  mask;
   logic        keeper_on;
   logic [15:0] int_top;
   logic        is_internal;
   logic        apb_setup;
   logic        apb_access;
   logic        busy;

   ////////////////////////////////////////////////////////////////////
   // Pin input synchroniser and high-address pins
   ////////////////////////////////////////////////////////////////////

   // Muxed line level into the core clock
   external_memory_interface_pin_sync #(.W(8)) u_ad_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (ad_in),
      .pin_sync (ad_sync)
   );

   // R4: one pin slice per high-address bit
   for (genvar g = 0; g < `HI_PINS; g++) begin : g_hi
      external_memory_interface_hi_pin #(.IDX(g)) u_hi_pin (
         .ext_en   (ext_en),
         .mask     (mask),
         .addr_bit (r_reg.addr[8 + g]),
         .port_dir (r_reg.pdir[g]),
         .port_out (r_reg.pout[g]),
         .pin_out  (hi_out[g]),
         .pin_oe   (hi_oe[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Decode of configuration
   ////////////////////////////////////////////////////////////////////

   // Field views of the configuration registers
   always_comb begin
      ext_en    = r_reg.ctrl[`CTRL_ENABLE_BIT];
      legacy    = r_reg.ctrl[`CTRL_LEGACY_BIT];
      mask      = r_reg.cfg[`CFG_MASK_MSB:`CFG_MASK_LSB];
      busy      = (r_reg.st != ST_IDLE);
      // R2: keeper gated by its own bit only
      keeper_on = r_reg.cfg[`CFG_KEEPER_BIT];
   end

   // R7: internal space ends at 0x10ff
   // R10: legacy layout ends internal space at 0x0fff
   always_comb begin
      int_top     = legacy ? `INT_TOP_LEGACY : `INT_TOP_NORMAL;
      is_internal = (cpu_req.addr <= int_top);
      apb_setup   = apb_req.psel && !apb_req.penable;
      apb_access  = apb_req.psel && apb_req.penable;
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   ////////////////////////////////////////////////////////////////////

   always_comb begin
      r_next = r_reg;

      // Read data and error prepared in the setup phase
      if (apb_setup) begin
         r_next.pslverr = 1'b0;
         r_next.prdata  = 32'h0000_0000;
         case (apb_req.paddr)
            `OFS_BUS_CONFIG: begin
               r_next.prdata[7:0] = r_reg.cfg;
            end
            `OFS_MEM_CTRL: begin
               r_next.prdata[1:0] = r_reg.ctrl;
            end
            `OFS_PORT_DIR: begin
               r_next.prdata[7:0] = r_reg.pdir;
            end
            `OFS_PORT_OUT: begin
               r_next.prdata[7:0] = r_reg.pout;
            end
            `OFS_STATUS: begin
               r_next.prdata[15:0] = {hi_oe, 3'h0, keeper_on && !r_reg.ad_oe, r_reg.st, busy};
            end
            default: begin
               r_next.pslverr = 1'b1;
            end
         endcase
      end

      // Register writes at the access edge
      if (apb_access && apb_req.pwrite) begin
         case (apb_req.paddr)
            `OFS_BUS_CONFIG: begin
               r_next.cfg = apb_req.pwdata[7:0];
               // R3: reserved positions never store
               r_next.cfg[`CFG_RES_MSB:`CFG_RES_LSB] = 4'h0;
            end
            `OFS_MEM_CTRL: begin
               r_next.ctrl = apb_req.pwdata[1:0];
            end
            `OFS_PORT_DIR: begin
               r_next.pdir = apb_req.pwdata[7:0];
            end
            `OFS_PORT_OUT: begin
               r_next.pout = apb_req.pwdata[7:0];
            end
            default: begin
               r_next.cfg = r_reg.cfg;
            end
         endcase
      end

      // R1: keeper holds the last driven level; the memory's level while it drives
      // Frozen otherwise, so a lagging synchroniser never glitches the held level
      if (r_reg.ad_oe) begin
         r_next.keep = r_reg.ad_val;
      end else if (!r_reg.rd_n) begin
         r_next.keep = ad_sync;
      end

      // External cycle sequencer
      case (r_reg.st)
         ST_IDLE: begin
            // R7: internal hits never leave idle
            if (cpu_req.valid && !is_internal && ext_en) begin
               // R8: whole address latched and driven
               r_next.addr   = cpu_req.addr;
               r_next.wdata  = cpu_req.wdata;
               r_next.write  = cpu_req.write;
               r_next.ad_val = cpu_req.addr[7:0];
               r_next.ad_oe  = 1'b1;
               r_next.ale    = 1'b1;
               r_next.st     = ST_ADDR;
            end
         end
         ST_ADDR: begin
            // Falling latch strobe captures the low byte
            r_next.ale = 1'b0;
            r_next.st  = ST_LATCH;
         end
         ST_LATCH: begin
            r_next.cnt = 3'(`STROBE_CYC - 1);
            r_next.st  = ST_STROBE;
            if (r_reg.write) begin
               r_next.ad_val = r_reg.wdata;
               r_next.wr_n   = 1'b0;
            end else begin
               r_next.ad_oe = 1'b0;
               r_next.rd_n  = 1'b0;
            end
         end
         ST_STROBE: begin
            if (r_reg.cnt != 3'h0) begin
               r_next.cnt = r_reg.cnt - 3'h1;
            end else if (r_reg.write) begin
               r_next.wr_n = 1'b1;
               r_next.st   = ST_DONE;
            end else begin
               r_next.cnt = 3'(`SYNC_CYC - 1);
               r_next.st  = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // Read strobe held until the synchronised data has settled
            if (r_reg.cnt != 3'h0) begin
               r_next.cnt = r_reg.cnt - 3'h1;
            end else begin
               r_next.rdata = ad_sync;
               r_next.rd_n  = 1'b1;
               r_next.st    = ST_DONE;
            end
         end
         ST_DONE: begin
            // Write data held one cycle past the strobe
            r_next.ad_oe = 1'b0;
            r_next.st    = ST_IDLE;
         end
         default: begin
            r_next.ad_oe = 1'b0;
            r_next.ale   = 1'b0;
            r_next.wr_n  = 1'b1;
            r_next.rd_n  = 1'b1;
            r_next.st    = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   ////////////////////////////////////////////////////////////////////

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg         <= '0;
         r_reg.cfg     <= `RST_BUS_CONFIG;
         r_reg.ctrl    <= `RST_MEM_CTRL;
         r_reg.pdir    <= `RST_PORT_DIR;
         r_reg.pout    <= `RST_PORT_OUT;
         r_reg.st      <= ST_IDLE;
         r_reg.wr_n    <= 1'b1;
         r_reg.rd_n    <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////

   // APB answer in the access phase
   always_comb begin
      apb_rsp.pready  = apb_access;
      apb_rsp.prdata  = r_reg.prdata;
      apb_rsp.pslverr = apb_access && r_reg.pslverr;
   end

   // CPU answer: internal and refused at once, external at cycle end
   always_comb begin
      cpu_rsp.internal = cpu_req.valid && is_internal;
      cpu_rsp.fault    = cpu_req.valid && !is_internal && !ext_en && !busy;
      cpu_rsp.ready    = (r_reg.st == ST_DONE)
                         || (!busy && cpu_req.valid && (is_internal || !ext_en));
      cpu_rsp.rdata    = r_reg.rdata;
   end

   // Pin outputs
   always_comb begin
      // R1: undriven lines show the held level with the keeper on
      xbus.ad_out     = r_reg.ad_oe ? r_reg.ad_val : r_reg.keep;
      xbus.ad_oe      = r_reg.ad_oe;
      xbus.ad_keep_oe = keeper_on && !r_reg.ad_oe;
      // R6: freed pins come from the port slices
      xbus.hi_out     = hi_out;
      xbus.hi_oe      = hi_oe;
      xbus.ale        = r_reg.ale;
      xbus.wr_n       = r_reg.wr_n;
      xbus.rd_n       = r_reg.rd_n;
      // R12: strobe pins owned by the interface while enabled
      xbus.ctl_oe     = ext_en;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////

   a_keeper_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
      keeper_on && !r_reg.ad_oe |-> xbus.ad_keep_oe && (xbus.ad_out == r_reg.keep))
      else $error("keeper not holding the muxed lines");

   a_keeper_free: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
      !ext_en && r_reg.cfg[`CFG_KEEPER_BIT] && !xbus.ad_oe |-> xbus.ad_keep_oe)
      else $error("keeper off while interface disabled");

   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
      apb_access && !apb_req.pwrite && (apb_req.paddr == `OFS_BUS_CONFIG) |-> apb_rsp.prdata[6:3] == 4'h0)
      else $error("reserved config bits read nonzero");

   a_full_hi_byte: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
      ext_en && (mask == 3'h0) |-> (hi_oe == 8'hff) && (hi_out == r_reg.addr[15:8]))
      else $error("high address byte not fully driven");

   a_mask_release: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
      ext_en && (mask == 3'h3) |-> (hi_oe[7:5] == r_reg.pdir[7:5]) && (hi_oe[4:0] == 5'h1f))
      else $error("mask three did not free exactly pins 7 to 5");

   a_port_revert: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
      !ext_en |-> (hi_oe == r_reg.pdir) && (hi_out == r_reg.pout))
      else $error("high port not following port settings");

   a_internal_noext: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
      !busy && cpu_req.valid && (cpu_req.addr <= 16'h10ff) && !legacy |=> !busy [*2])
      else $error("internal address started an external cycle");

   a_full_addr: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
      $rose(xbus.ale) |-> xbus.ad_oe && (xbus.ad_out == r_reg.addr[7:0]) ##1 !xbus.ale)
      else $error("low address byte not driven during latch strobe");

   a_legacy_base: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
      !busy && ext_en && legacy && cpu_req.valid && (cpu_req.addr == 16'h1000)
      |=> (r_reg.st == ST_ADDR) ##1 (r_reg.st == ST_LATCH))
      else $error("legacy address 0x1000 did not go external");

   a_zero_window: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
      ext_en && (mask == 3'h3) && (r_reg.pdir == 8'hff) && (r_reg.pout == 8'h00) |-> hi_out[7:5] == 3'h0)
      else $error("freed pins do not present zero upper address");

   a_pin_takeover: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
      $rose(ext_en) |-> xbus.ctl_oe && (mask != 3'h0 || hi_oe == 8'hff))
      else $error("enable did not take over interface pins");

endmodule

/* File: test/sram_model.sv */
// Behavioural external SRAM of 32 KB behind an address latch.
// Assumes the bench resolves the shared muxed lines and feeds their level.
module sram_model
   import external_memory_interface_pkg::*;
(
   input  wire logic       ale,    // Latch strobe, active high
   input  wire logic       wr_n,   // Write strobe, active low
   input  wire logic       rd_n,   // Read strobe, active low
   input  wire logic [7:0] ad,     // Muxed line level
   input  wire logic [7:0] hi,     // High-address pin level
   output logic      [7:0] dq,     // Read data onto muxed lines
   output logic            dq_oe   // Memory drives muxed lines
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [0:32767];
   logic [14:0] lat;
   ////////////////////////////////////////////////////////////
   // top bit unconnected
   always @(ale or ad or hi) begin
      if (ale) lat = {hi[6:0], ad};
   end
   // Store on rising write strobe
   always @(posedge wr_n) begin
      mem[lat] <= ad;
   end
   // Drive while read strobe is low
   assign dq_oe = !rd_n;
   assign dq    = mem[lat];
endmodule

/* File: test/tb_ext_mem_bus_keeper_addr_mask.sv */
// Testbench for the external memory configuration block.
// Assumes APB at zero wait and a 32 KB memory model on the far side.
`include "external_memory_interface_defines.svh"
module tb_ext_mem_bus_keeper_addr_mask;
   import external_memory_interface_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk = 1'b0;
   logic       rst_n    = 1'b0;
   apb_req_s   apb_req  = '0;
   apb_rsp_s   apb_rsp;
   cpu_req_s   cpu_req  = '0;
   cpu_rsp_s   cpu_rsp;
   xbus_s      xbus;
   logic [7:0] ad_in;
   logic [7:0] last_ad = 8'h00;
   logic [7:0] dq;
   logic       dq_oe;
   int         error_cnt = 0;
   int         tests_run = 0;
   logic [31:0] rd;
   logic        er;
   logic [7:0]  r8;
   logic        in, f;
   int          ales;
   ////////////////////////////////////////////////////////////
   // Clock, instances and muxed line resolution
   always #5 core_clk = ~core_clk;
   external_memory_interface_ctrl u_external_memory_interface_ctrl (.core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .ad_in(ad_in), .xbus(xbus));
   sram_model u_sram_model (.ale(xbus.ale), .wr_n(xbus.wr_n), .rd_n(xbus.rd_n), .ad(ad_in),
      .hi(xbus.hi_out), .dq(dq), .dq_oe(dq_oe));
   // Floating lines toggle so no stale level passes
   always_comb begin
      if (xbus.ad_oe) ad_in = xbus.ad_out;
      else if (dq_oe) ad_in = dq;
      else if (xbus.ad_keep_oe) ad_in = xbus.ad_out;
      else ad_in = ~last_ad;
   end
   always @(posedge core_clk) last_ad <= ad_in;
   ////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
      ales = 0;
      @(posedge core_clk);
      cpu_req <= '{valid:1'b1, write:w, addr:a, wdata:d};
      do begin
         @(posedge core_clk);
         if (xbus.ale === 1'b1) ales++;
      end while (cpu_rsp.ready !== 1'b1);
      r8 = cpu_rsp.rdata;
      in = cpu_rsp.internal;
      f  = cpu_rsp.fault;
      cpu_req.valid <= 1'b0;
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs;
      apb(1'b0, `OFS_BUS_CONFIG, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b1, `OFS_BUS_CONFIG, 32'hff);
      apb(1'b0, `OFS_BUS_CONFIG, 32'h0);
      cmp(rd, 32'h87);
      apb(1'b0, 8'h14, 32'h0);
      cmp({31'h0, er}, 32'h1);
      apb(1'b1, `OFS_BUS_CONFIG, 32'h0);
   endtask
   task automatic t_keeper;
      apb(1'b1, `OFS_BUS_CONFIG, 32'h80);
      @(posedge core_clk);
      cmp({31'h0, xbus.ad_keep_oe}, 32'h1);
      cmp({31'h0, xbus.ctl_oe}, 32'h0);
      apb(1'b1, `OFS_BUS_CONFIG, 32'h00);
      @(posedge core_clk);
      cmp({31'h0, xbus.ad_keep_oe}, 32'h0);
   endtask
   task automatic t_mask;
      logic [7:0] dm;
      apb(1'b1, `OFS_MEM_CTRL, 32'h1);
      apb(1'b1, `OFS_PORT_DIR, 32'h0f);
      apb(1'b1, `OFS_PORT_OUT, 32'h3c);
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, `OFS_BUS_CONFIG, k);
         @(posedge core_clk);
         dm = (k == 7) ? 8'h00 : (8'hff >> k);
         cmp(xbus.hi_oe, dm | (~dm & 8'h0f));
         cmp(xbus.hi_out & ~dm & 8'h0f, 8'h3c & ~dm & 8'h0f);
         cmp({31'h0, xbus.ctl_oe}, 32'h1);
      end
      apb(1'b1, `OFS_BUS_CONFIG, 32'h0);
      @(posedge core_clk);
      cmp(xbus.hi_oe, 8'hff);
   endtask
   task automatic t_map;
      cpu(1'b1, 16'h10ff, 8'h11);
      cmp({in, 7'h0, ales[7:0]}, 16'h8000);
      cpu(1'b1, 16'h1100, 8'h22);
      cmp({in, 7'h0, ales[7:0]}, 16'h0001);
      apb(1'b1, `OFS_MEM_CTRL, 32'h3);
      cpu(1'b1, 16'h1000, 8'h33);
      cmp({in, 7'h0, ales[7:0]}, 16'h0001);
      cpu(1'b0, 16'h0fff, 8'h00);
      cmp({in, 7'h0, ales[7:0]}, 16'h8000);
      apb(1'b1, `OFS_MEM_CTRL, 32'h1);
   endtask
   task automatic t_alias;
      apb(1'b1, `OFS_BUS_CONFIG, 32'h80);
      // aliases kept inside 0x8000 to 0x90ff
      cpu(1'b1, 16'h8105, 8'h5a);
      cmp(u_sram_model.mem[15'h0105], 8'h5a);
      repeat (3) @(posedge core_clk);
      cmp(ad_in, 8'h5a);
      cpu(1'b0, 16'h8105, 8'h00);
      cmp(r8, 8'h5a);
      cpu(1'b1, 16'h90ff, 8'ha3);
      cmp(u_sram_model.mem[15'h10ff], 8'ha3);
      cpu(1'b0, 16'h90ff, 8'h00);
      cmp(r8, 8'ha3);
   endtask
   task automatic t_fullspace;
      apb(1'b1, `OFS_PORT_DIR, 32'hff);
      apb(1'b1, `OFS_PORT_OUT, 32'h00);
      apb(1'b1, `OFS_BUS_CONFIG, 32'h03);
      cpu(1'b1, 16'h2001, 8'haa);
      cmp(u_sram_model.mem[15'h0001], 8'haa);
      apb(1'b1, `OFS_BUS_CONFIG, 32'h00);
      cpu(1'b1, 16'h2001, 8'h55);
      cmp(u_sram_model.mem[15'h2001], 8'h55);
      cmp(xbus.hi_out, 8'h20);
      cmp(u_sram_model.mem[15'h0001], 8'haa);
   endtask
   task automatic t_refuse;
      apb(1'b1, `OFS_MEM_CTRL, 32'h0);
      cpu(1'b1, 16'h2000, 8'h77);
      cmp({f, 7'h0, ales[7:0]}, 16'h8000);
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_keeper();
      t_mask();
      t_map();
      t_alias();
      t_fullspace();
      t_refuse();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      complete_run();
   end
endmodule
